// ===== logic/nvmua_pkg.sv
/*
  Shared constants and types of the NVM unlock and data EEPROM access block.
  Assumes a single 50 MHz system clock and AHB-Lite register access.
*/
package nvmua_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int EE_WRITE_NS   = 4000;
  localparam int EE_WRITE_CYC  = (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_OP_NS   = 2000;
  localparam int FLASH_OP_CYC  = (FLASH_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 16;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY  = 8'h04;
  localparam logic [7:0] OFS_ADRL = 8'h08;
  localparam logic [7:0] OFS_ADRH = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  localparam int CTRL_RD     = 0;
  localparam int CTRL_WR     = 1;
  localparam int CTRL_WRITE_PERMIT_BIT   = 2;
  localparam int CTRL_FREE   = 4;
  localparam int CTRL_REG_LO = 6;
  localparam int CTRL_REG_HI = 7;
  localparam int STAT_FLAG   = 0;
  localparam int STAT_BUSY   = 1;
  localparam int STAT_STALL  = 2;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [1:0] REGION_EE  = 2'h0;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_KEY1  = 2'b01,
    SEQ_ARMED = 2'b10
  } nvmua_seq_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_EE    = 2'b01,
    OP_FLASH = 2'b10
  } nvmua_op_t;
endpackage

// ===== logic/nvmua_if.sv
/*
  Internal carrier between the controller, the unlock sequencer and the EEPROM array.
  Assumes all three run on the same clock.
*/
`timescale 1ns/100ps
interface nvmua_if #(parameter int ADDR_W = 10);
  logic              stepValid;
  logic              keyWr;
  logic [7:0]        keyVal;
  logic              disturb;
  logic              armed;
  logic              memRdEn;
  logic              memWrEn;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0]        memWdata;
  logic [7:0]        memRdata;

  modport ctl (output stepValid, keyWr, keyVal, disturb, memRdEn, memWrEn, memAddr,
               memWdata, input armed, memRdata);
  modport seq (input stepValid, keyWr, keyVal, disturb, output armed);
  modport mem (input memRdEn, memWrEn, memAddr, memWdata, output memRdata);
endinterface

// ===== logic/nvmua_unlock_seq.sv
/*
  Two-key unlock sequencer.
  Assumes one step pulse per completed bus transfer from the controller.
*/
`timescale 1ns/100ps
module nvmua_unlock_seq
  import nvmua_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  nvmua_if.seq     sq
);
  nvmua_seq_t state_ff;
  nvmua_seq_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (sq.disturb) begin
      nxt_state = SEQ_IDLE;
    end else if (sq.stepValid) begin
      case (state_ff)
        SEQ_IDLE: begin
          nxt_state = (sq.keyWr && sq.keyVal == KEY_FIRST) ? SEQ_KEY1 : SEQ_IDLE;
        end
        SEQ_KEY1: begin
          // Anything but the second key breaks the sequence
          nxt_state = (sq.keyWr && sq.keyVal == KEY_SECOND) ? SEQ_ARMED : SEQ_IDLE;
        end
        default: begin
          nxt_state = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= SEQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sq.armed = (state_ff == SEQ_ARMED);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_SEQ_ORDER: assert property (state_ff == SEQ_ARMED && $past(state_ff) != SEQ_ARMED
    |-> $past(state_ff) == SEQ_KEY1 && $past(sq.keyVal) == KEY_SECOND)
    else $error("armed without second key after first");
  AST_SEQ_BREAK: assert property (sq.stepValid && !sq.keyWr |=> state_ff == SEQ_IDLE)
    else $error("non-key access did not reset the sequence");
endmodule

// ===== logic/nvmua_eeprom.sv
/*
  Data EEPROM byte array with a registered read port.
  Assumes the controller holds address and data stable while a write is pending.
*/
`timescale 1ns/100ps
module nvmua_eeprom
  import nvmua_pkg::*;
#(
  parameter int ADDR_W = 10
)(
  input wire logic clock,
  input wire logic rst,
  nvmua_if.mem     mm
);
  logic [7:0] mem [2**ADDR_W];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = mm.memRdEn ? mem[mm.memAddr] : rdata_ff;
  end

  // Array contents survive reset, as a nonvolatile store should
  always_ff @(posedge clock) begin
    if (mm.memWrEn) begin
      mem[mm.memAddr] <= mm.memWdata; // Whole byte replaced: erase plus program
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign mm.memRdata = rdata_ff;
endmodule

// ===== logic/nvmua_nvm_ctrl.sv
/*
  NVM access controller: AHB-Lite register slave, unlock gating, write timing.
  Assumes a single AHB-Lite master and the debug/interrupt disturb input
  arriving asynchronously.
*/
// How it works
// - Protected operations only after full unlock
// - Disturbed or gapped sequence cancels the operation
// - Stall processor during flash-type operations
// - Read byte lands in data register two cycles after the request
// - Data register holds until read or write
// - Each byte write needs its own unlock
// - Start bit blocked while write permit clear
// - Permit and start never set together
// - Hardware never clears write permit
// - Control, address and data registers frozen while a write runs
// - Clearing permit does not abort write
// - Byte write includes automatic erase
// - CPU runs; end clears start, sets flag
// - Completion flag sticky until software clears
`timescale 1ns/100ps
module nvmua_nvm_ctrl
  import nvmua_pkg::*;
#(
  parameter int ADDR_W  = 10,
  parameter int EE_CYC  = EE_WRITE_CYC,
  parameter int FLS_CYC = FLASH_OP_CYC
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        seqDisturb,
  output logic             cpuStall,
  output logic             completionFlag
);
  nvmua_if #(.ADDR_W(ADDR_W)) link ();

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  logic             phaseAct_ff;
  logic             nxt_phaseAct;
  logic             phaseWr_ff;
  logic             nxt_phaseWr;
  logic [7:0]       phaseOfs_ff;
  logic [7:0]       nxt_phaseOfs;
  logic             readyOut_ff;
  logic             nxt_readyOut;
  logic [31:0]      hrdata_ff;
  logic [31:0]      nxt_hrdata;
  // Control state
  logic             wr_ff;
  logic             nxt_wr;
  logic             write_permit_bit_ff;
  logic             nxt_write_permit_bit;
  logic             free_ff;
  logic             nxt_free;
  logic [1:0]       region_ff;
  logic [1:0]       nxt_region;
  logic [15:0]      adr_ff;
  logic [15:0]      nxt_adr;
  logic [7:0]       data_ff;
  logic [7:0]       nxt_data;
  logic             flag_ff;
  logic             nxt_flag;
  logic             stall_ff;
  logic             nxt_stall;
  logic             rdPend_ff;
  logic             nxt_rdPend;
  nvmua_op_t        op_ff;
  nvmua_op_t        nxt_op;
  logic [TMR_W-1:0] timer_ff;
  logic [TMR_W-1:0] nxt_timer;
  logic             meta_ff;
  logic             sync_ff;

  logic accept, act, busy, done, start, wrAttempt, flagClr;
  logic wrCtrl, wrAdrl, wrAdrh, wrData;

  function automatic logic hitWr(input logic a, input logic w, input logic [7:0] o,
                                 input logic [7:0] t);
    hitWr = a && w && (o == t);
  endfunction

  assign accept    = hsel && htrans[1] && hready;
  // Every transfer gets one wait state so read data leaves a flop
  assign act       = phaseAct_ff && !readyOut_ff;
  assign wrCtrl    = hitWr(act, phaseWr_ff, phaseOfs_ff, OFS_CTRL);
  assign wrAdrl    = hitWr(act, phaseWr_ff, phaseOfs_ff, OFS_ADRL);
  assign wrAdrh    = hitWr(act, phaseWr_ff, phaseOfs_ff, OFS_ADRH);
  assign wrData    = hitWr(act, phaseWr_ff, phaseOfs_ff, OFS_DATA);
  assign flagClr   = hitWr(act, phaseWr_ff, phaseOfs_ff, OFS_STAT) && hwdata[STAT_FLAG];
  assign busy      = (op_ff != OP_IDLE);
  assign done      = busy && (timer_ff == TMR_W'(1));
  assign wrAttempt = wrCtrl && hwdata[CTRL_WR];
  // Permit must already be set before this write, so one write cannot set both;
  // a disturbance seen during the start write itself still cancels it
  assign start     = wrAttempt && write_permit_bit_ff && link.armed && !busy
                     && !link.disturb;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and array links
  assign link.stepValid = act;
  assign link.keyWr     = hitWr(act, phaseWr_ff, phaseOfs_ff, OFS_KEY);
  assign link.keyVal    = hwdata[7:0];
  assign link.disturb   = sync_ff;
  assign link.memRdEn   = wrCtrl && hwdata[CTRL_RD] && !busy && !start
                          && hwdata[CTRL_REG_HI:CTRL_REG_LO] == REGION_EE;
  assign link.memWrEn   = done && op_ff == OP_EE;
  assign link.memAddr   = adr_ff[ADDR_W-1:0];
  assign link.memWdata  = data_ff;

  nvmua_unlock_seq u_seq (
    .clock (clock),
    .rst   (rst),
    .sq    (link.seq)
  );

  nvmua_eeprom #(.ADDR_W(ADDR_W)) u_mem (
    .clock (clock),
    .rst   (rst),
    .mm    (link.mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phases and read mux
  always_comb begin
    nxt_phaseAct = accept ? 1'b1 : (act ? 1'b0 : phaseAct_ff);
    nxt_phaseWr  = accept ? hwrite : phaseWr_ff;
    nxt_phaseOfs = accept ? haddr[7:0] : phaseOfs_ff;
    nxt_readyOut = !accept;
    nxt_hrdata   = hrdata_ff;
    if (act && !phaseWr_ff) begin
      case (phaseOfs_ff)
        OFS_CTRL: nxt_hrdata = {24'h000000, region_ff, 1'b0, free_ff, 1'b0, write_permit_bit_ff,
                                wr_ff, 1'b0};
        OFS_ADRL: nxt_hrdata = {24'h000000, adr_ff[7:0]};
        OFS_ADRH: nxt_hrdata = {24'h000000, adr_ff[15:8]};
        OFS_DATA: nxt_hrdata = {24'h000000, data_ff};
        OFS_STAT: nxt_hrdata = {29'h00000000, stall_ff, busy, flag_ff};
        default:  nxt_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phaseAct_ff <= 1'b0;
      phaseWr_ff  <= 1'b0;
      phaseOfs_ff <= 8'h00;
      readyOut_ff <= 1'b1;
      hrdata_ff   <= 32'h00000000;
    end else begin
      phaseAct_ff <= nxt_phaseAct;
      phaseWr_ff  <= nxt_phaseWr;
      phaseOfs_ff <= nxt_phaseOfs;
      readyOut_ff <= nxt_readyOut;
      hrdata_ff   <= nxt_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers and operation timing
  always_comb begin
    nxt_write_permit_bit   = write_permit_bit_ff;
    nxt_free   = free_ff;
    nxt_region = region_ff;
    nxt_adr    = adr_ff;
    nxt_data   = data_ff;
    nxt_wr     = wr_ff;
    nxt_op     = op_ff;
    nxt_timer  = timer_ff;
    nxt_stall  = stall_ff;
    nxt_rdPend = link.memRdEn;
    // Control, address and data writes while busy are dropped, including a clear of the permit bit
    if (!busy) begin
      if (wrCtrl) begin
        nxt_write_permit_bit   = hwdata[CTRL_WRITE_PERMIT_BIT];
        nxt_free   = hwdata[CTRL_FREE];
        nxt_region = hwdata[CTRL_REG_HI:CTRL_REG_LO];
      end
      if (wrAdrl) begin
        nxt_adr[7:0] = hwdata[7:0];
      end
      if (wrAdrh) begin
        nxt_adr[15:8] = hwdata[7:0];
      end
      if (wrData) begin
        nxt_data = hwdata[7:0];
      end
    end
    if (rdPend_ff) begin
      nxt_data = link.memRdata;
    end
    if (start) begin
      nxt_wr = 1'b1;
      if (hwdata[CTRL_REG_HI:CTRL_REG_LO] == REGION_EE) begin
        nxt_op    = OP_EE; // CPU keeps running
        nxt_timer = TMR_W'(EE_CYC);
      end else begin
        nxt_op    = OP_FLASH;
        nxt_timer = TMR_W'(FLS_CYC);
        nxt_stall = 1'b1;
      end
    end else if (done) begin
      nxt_op    = OP_IDLE;
      nxt_wr    = 1'b0;
      nxt_stall = 1'b0;
      nxt_timer = TMR_W'(0);
    end else if (busy) begin
      nxt_timer = timer_ff - TMR_W'(1);
    end
    // A completion in the same cycle as a clear keeps the flag set
    nxt_flag = (flag_ff && !flagClr) || done;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff     <= 1'b0;
      write_permit_bit_ff   <= 1'b0;
      free_ff   <= 1'b0;
      region_ff <= 2'h0;
      adr_ff    <= 16'h0000;
      data_ff   <= 8'h00;
      flag_ff   <= 1'b0;
      stall_ff  <= 1'b0;
      rdPend_ff <= 1'b0;
      op_ff     <= OP_IDLE;
      timer_ff  <= {TMR_W{1'b0}};
      meta_ff   <= 1'b0;
      sync_ff   <= 1'b0;
    end else begin
      wr_ff     <= nxt_wr;
      write_permit_bit_ff   <= nxt_write_permit_bit;
      free_ff   <= nxt_free;
      region_ff <= nxt_region;
      adr_ff    <= nxt_adr;
      data_ff   <= nxt_data;
      flag_ff   <= nxt_flag;
      stall_ff  <= nxt_stall;
      rdPend_ff <= nxt_rdPend;
      op_ff     <= nxt_op;
      timer_ff  <= nxt_timer;
      meta_ff   <= seqDisturb;
      sync_ff   <= meta_ff;
    end
  end

  assign hreadyout      = readyOut_ff;
  assign hresp          = 1'b0;
  assign hrdata         = hrdata_ff;
  assign cpuStall       = stall_ff;
  assign completionFlag = flag_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_START_GATED: assert property ($rose(wr_ff) |-> $past(link.armed) && $past(write_permit_bit_ff))
    else $error("operation started without unlock and permit");
  AST_NO_JOINT_SET: assert property (wrAttempt && hwdata[CTRL_WRITE_PERMIT_BIT] && !write_permit_bit_ff && !wr_ff
    |=> !wr_ff)
    else $error("permit and start set by one write");
  AST_WRITE_PERMIT_BIT_KEPT: assert property (write_permit_bit_ff && !wrCtrl |=> write_permit_bit_ff)
    else $error("write permit cleared by hardware");
  AST_FROZEN: assert property (busy |=> $stable(adr_ff) && $stable(region_ff))
    else $error("registers changed during a write");
  AST_WR_HELD: assert property (op_ff == OP_EE && timer_ff > TMR_W'(1) |=> wr_ff)
    else $error("write aborted before its end");
  AST_EE_DONE: assert property (done && op_ff == OP_EE
    |=> !wr_ff && flag_ff && op_ff == OP_IDLE)
    else $error("write end did not clear start and set flag");
  AST_READ_NEXT: assert property (link.memRdEn |=> ##1 data_ff == $past(link.memRdata))
    else $error("read byte not in data register");
  AST_DATA_HOLD: assert property (!rdPend_ff && !(wrData && !busy) |=> $stable(data_ff))
    else $error("data register changed without cause");
  AST_FLAG_STICKY: assert property (flag_ff && !flagClr |=> flag_ff)
    else $error("completion flag lost");
  AST_FLASH_STALL: assert property (op_ff == OP_FLASH |-> cpuStall)
    else $error("no stall during flash operation");
  // An unlock is used up by the write it starts, so a second byte needs a new one
  AST_ONE_SHOT: assert property (start |=> !link.armed)
    else $error("unlock reused after a start");
  AST_NO_PERMIT: assert property (wrAttempt && !write_permit_bit_ff && !wr_ff |=> !wr_ff)
    else $error("start accepted without write permit");
  AST_DISTURB_BLOCKS: assert property (link.disturb |-> !start)
    else $error("start accepted during a disturbance");
  AST_PERMIT_IGNORED: assert property (busy && wrCtrl |=> write_permit_bit_ff == $past(write_permit_bit_ff))
    else $error("permit changed during a write");
  AST_DATA_FROZEN: assert property (busy |=> $stable(data_ff))
    else $error("data register changed during a write");
  AST_EE_RUNS: assert property (op_ff == OP_EE |-> !cpuStall)
    else $error("processor stalled during a byte write");
  AST_FLASH_RESUME: assert property (done && op_ff == OP_FLASH |=> !cpuStall && flag_ff)
    else $error("processor not resumed after flash operation");
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench for the NVM access controller: unlock gating, EEPROM byte
  read and write, register freeze, flash-type stall and the sticky completion flag.
  Assumes the controller is the only AHB-Lite slave, with hready fed from hreadyout.
*/
`timescale 1ns/100ps
module tb_top
  import nvmua_pkg::*;
;
  localparam int         EE_N  = 12;
  localparam int         FLS_N = 6;
  localparam int         LIMIT = 6000;
  localparam logic [7:0] C_RD  = 8'h01 << CTRL_RD;
  localparam logic [7:0] C_WR  = 8'h01 << CTRL_WR;
  localparam logic [7:0] C_EN  = 8'h01 << CTRL_WRITE_PERMIT_BIT;
  localparam logic [7:0] C_FLS = 8'h01 << CTRL_REG_LO;

  logic        clock;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        seqDisturb;
  logic        cpuStall;
  logic        completionFlag;
  int          n_mismatch;
  int          comparisons;
  int          cycles;

  nvmua_nvm_ctrl #(.ADDR_W(10), .EE_CYC(EE_N), .FLS_CYC(FLS_N)) dut (
    .clock          (clock),
    .rst            (rst),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (3'h2),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .hrdata         (hrdata),
    .seqDisturb     (seqDisturb),
    .cpuStall       (cpuStall),
    .completionFlag (completionFlag)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hung design must still reach the verdict
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, {24'h0, e});
  endtask

  task automatic unlock(input logic [7:0] c);
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_KEY, KEY_SECOND);
    wr(OFS_CTRL, c);
  endtask

  // Polls the flag under a bounded count, so a missing completion shows as a mismatch
  task automatic wait_done();
    logic [31:0] q;
    int          i;
    i = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0, q);
      i++;
    end while (q[STAT_FLAG] !== 1'b1 && i < 40);
    chk({31'h0, q[STAT_FLAG]}, 32'h1);
    chk({31'h0, completionFlag}, 32'h1);
  endtask

  task automatic ee_read(input logic [7:0] e);
    wr(OFS_CTRL, C_RD | C_EN);
    rd(OFS_DATA, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    seqDisturb = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({30'h0, cpuStall, completionFlag}, 32'h0);
    rd(OFS_STAT, 8'h00);
    rd(OFS_KEY, 8'h00);
    rd(8'h18, 8'h00);
    // First byte written, then overwritten with complementary bits
    wr(OFS_ADRL, 8'h12);
    wr(OFS_ADRH, 8'h01);
    wr(OFS_DATA, 8'h5a);
    wr(OFS_CTRL, C_EN);
    unlock(C_EN | C_WR);
    rd(OFS_CTRL, C_EN | C_WR);
    chk({31'h0, cpuStall}, 32'h0);
    wait_done();
    chk({31'h0, cpuStall}, 32'h0);
    rd(OFS_CTRL, C_EN);
    rd(OFS_STAT, 8'h01);
    wr(OFS_STAT, 8'h01);
    rd(OFS_STAT, 8'h00);
    ee_read(8'h5a);
    wr(OFS_DATA, 8'ha5);
    wr(OFS_CTRL, C_EN | C_WR);
    rd(OFS_STAT, 8'h00);
    unlock(C_EN | C_WR);
    // Changes while busy must be dropped, including the permit clear
    wr(OFS_DATA, 8'h33);
    wr(OFS_ADRL, 8'h00);
    wr(OFS_CTRL, 8'h00);
    wait_done();
    rd(OFS_CTRL, C_EN);
    wr(OFS_STAT, 8'h01);
    ee_read(8'ha5);
    wr(OFS_ADRL, 8'h40);
    rd(OFS_DATA, 8'ha5);
    rd(OFS_DATA, 8'ha5);
    // Back to the written byte with fresh data, so a false start below would show
    wr(OFS_ADRL, 8'h12);
    wr(OFS_DATA, 8'hc3);
    // Each broken sequence below must leave the machine idle
    wr(OFS_KEY, KEY_SECOND);
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_CTRL, C_EN | C_WR);
    rd(OFS_STAT, 8'h00);
    wr(OFS_KEY, KEY_FIRST);
    rd(OFS_STAT, 8'h00);
    wr(OFS_KEY, KEY_SECOND);
    wr(OFS_CTRL, C_EN | C_WR);
    rd(OFS_STAT, 8'h00);
    wr(OFS_KEY, KEY_FIRST);
    seqDisturb <= 1'b1;
    wr(OFS_KEY, KEY_SECOND);
    seqDisturb <= 1'b0;
    wr(OFS_CTRL, C_EN | C_WR);
    rd(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'h00);
    unlock(C_WR);
    rd(OFS_STAT, 8'h00);
    rd(OFS_CTRL, 8'h00);
    unlock(C_EN | C_WR);
    rd(OFS_STAT, 8'h00);
    ee_read(8'ha5);
    // Flash-type region: processor stalled for the whole operation
    wr(OFS_CTRL, C_EN | C_FLS);
    unlock(C_EN | C_FLS | C_WR);
    @(negedge clock);
    chk({31'h0, cpuStall}, 32'h1);
    @(posedge clock);
    wait_done();
    chk({31'h0, cpuStall}, 32'h0);
    // Erase-select is only stored; a read request outside the EEPROM region does nothing
    wr(OFS_CTRL, C_RD | C_FLS | 8'h10);
    rd(OFS_CTRL, C_FLS | 8'h10);
    rd(OFS_DATA, 8'ha5);
    // Reset in mid-run clears the sticky flag
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({30'h0, cpuStall, completionFlag}, 32'h0);
    rd(OFS_CTRL, 8'h00);
    wrap_up();
  end
endmodule
